// *** rtl/ncr_pkg.sv ***
// ncr_pkg: constants, types and pin bundles for the cache read host controller
// assumes a single 25 MHz core clock and an 8-bit multiplexed flash port
package ncr_pkg;

    // flash command bytes
    localparam logic [7:0] CMD_READ_SETUP = 8'h00;
    localparam logic [7:0] CMD_READ_CONFIRM = 8'h30;
    localparam logic [7:0] CMD_CACHE_NEXT = 8'h31;
    localparam logic [7:0] CMD_CACHE_LAST = 8'h3f;
    localparam logic [7:0] CMD_STATUS = 8'h70;

    // status byte field positions
    localparam int STAT_READY_BIT = 6;
    localparam int STAT_WP_BIT = 7;

    // address layout: two column cycles, three row cycles
    localparam int COL_CYCLES = 2;
    localparam int ROW_CYCLES = 3;
    localparam int ADDR_CYCLES = COL_CYCLES + ROW_CYCLES;
    localparam int PAGE_BITS = 6;
    localparam int BLOCK_BITS = 10;

    // geometry defaults
    localparam int PAGE_BYTES_DEF = 2112;
    localparam int PAGES_PER_BLOCK_DEF = 64;

    // timing: write-high to busy-valid settle, rounded up to whole cycles
    localparam int CLK_PERIOD_NS = 40;
    localparam int T_WB_NS = 100;
    localparam int WB_CYCLES = (T_WB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // reset value of wp_n and idle value of ce_n in the pin bundle
    localparam logic WP_N_RST = 1'b0;
    localparam logic CE_N_RST = 1'b1;

    typedef enum logic [3:0] {
        ST_INIT_CMD,
        ST_INIT_POLL,
        ST_IDLE,
        ST_RD_CMD0,
        ST_RD_ADDR,
        ST_RD_CMD30,
        ST_WAIT_RDY,
        ST_CACHE_CMD,
        ST_XFER
    } ncr_state_t;

    // one cache read run request
    typedef struct packed {
        logic [BLOCK_BITS-1:0] block;
        logic [PAGE_BITS-1:0] page;
        logic [PAGE_BITS:0] count;
    } ncr_req_t;

    // pins driven toward the flash
    typedef struct packed {
        logic ce_n;
        logic cle;
        logic ale;
        logic we_n;
        logic re_n;
        logic wp_n;
        logic [7:0] io_out;
        logic io_oe;
    } ncr_pins_t;

endpackage

// *** rtl/ncr_buf.sv ***
// ncr_buf: small valid/ready buffer for the read byte stream
// assumes one clock; ce low freezes every register
`timescale 1ns/1ps
module ncr_buf import ncr_pkg::*; #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic ce,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("ncr_buf depth must be a power of two, at least 2");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    wire push = ce && in_valid && in_ready;
    wire pop = ce && out_valid && out_ready;

    // honest full and empty straight from the fill count
    assign in_ready = (cnt_q != AW'(0) + (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];

    // storage carries no reset, only the pointers and fill count do
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    // pointers and fill count
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) wr_q <= wr_q + AW'(1);
            if (pop) rd_q <= rd_q + AW'(1);
            if (push && !pop) cnt_q <= cnt_q + (AW+1)'(1);
            else if (pop && !push) cnt_q <= cnt_q - (AW+1)'(1);
        end
    end
endmodule

// *** rtl/ncr_host.sv ***
// ncr_host: host sequencer for pipelined cache page reads from a NAND flash
// assumes the flash pins are sampled synchronously to core_clk (25 MHz)
`timescale 1ns/1ps
// Notes on behaviour
// - run must stay inside one erase block
// - normal 00h-30h read precedes any 31h
// - last page of run uses 3Fh
// - shared busy line low means busy
// - only 70h issued until init ready
// - never assert write-protect while busy
// - write-protect stays high through operations
// - write-protect asserted while power unstable; the code asserts it only once idle with the line ready
module ncr_host import ncr_pkg::*; #(
    parameter int PAGE_BYTES = PAGE_BYTES_DEF,
    parameter int PAGES_PER_BLOCK = PAGES_PER_BLOCK_DEF,
    parameter int BUF_DEPTH = 2
) (
    // clock, reset, enable
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic ce,
    // run request
    input wire logic req_valid,
    output logic req_ready,
    input wire ncr_req_t req,
    output logic req_err,
    output logic run_done,
    // read byte stream
    output logic dout_valid,
    input wire logic dout_ready,
    output logic [7:0] dout_data,
    // control and state
    input wire logic pwr_ok,
    input wire logic wp_release,
    output logic init_done,
    // flash pins
    output ncr_pins_t pins,
    input wire logic [7:0] io_in,
    input wire logic rb_n
);
    localparam int BW = $clog2(PAGE_BYTES + 1);

    // the byte counter also walks the address cycles, so it must reach them
    if (PAGE_BYTES < 2 || (1 << BW) < ADDR_CYCLES ||
        PAGES_PER_BLOCK < 2 || PAGES_PER_BLOCK > (1 << PAGE_BITS))
    begin : g_bad_geom
        $error("ncr_host geometry out of range");
    end

    ncr_state_t state_q, state_d;
    logic ph_q;
    logic [BW-1:0] cnt_q;
    logic [PAGE_BITS:0] left_q;
    ncr_req_t run_q;
    logic [$clog2(WB_CYCLES + 1)-1:0] wb_q;
    logic in_cache_q;
    logic wp_n_q;
    logic init_done_q;
    logic err_q;
    logic done_q;
    logic confirm_seen_q;
    logic buf_in_ready;

    // strobe phase: ph 0 = strobe low, ph 1 = strobe high
    function automatic logic is_write_step(input ncr_state_t s);
        return s == ST_INIT_CMD || s == ST_RD_CMD0 || s == ST_RD_ADDR ||
               s == ST_RD_CMD30 || s == ST_CACHE_CMD;
    endfunction

    function automatic logic is_read_step(input ncr_state_t s);
        return s == ST_INIT_POLL || s == ST_XFER;
    endfunction

    // address byte for cycle idx; row = block,page
    wire [PAGE_BITS+BLOCK_BITS-1:0] row = {run_q.block, run_q.page};
    wire [23:0] row_bytes = {{(24-PAGE_BITS-BLOCK_BITS){1'b0}}, row};
    wire [7:0] addr_byte = (cnt_q < BW'(COL_CYCLES)) ? 8'h00 :
                           (cnt_q == BW'(COL_CYCLES)) ? row_bytes[7:0] :
                           (cnt_q == BW'(COL_CYCLES + 1)) ? row_bytes[15:8] :
                           row_bytes[23:16];

    // shared busy line: any device low means busy
    wire line_busy = !rb_n;
    wire last_cache = (left_q == (PAGE_BITS+1)'(1));
    wire [7:0] cache_cmd = last_cache ? CMD_CACHE_LAST : CMD_CACHE_NEXT;
    wire [7:0] cmd_byte = (state_q == ST_INIT_CMD) ? CMD_STATUS :
                          (state_q == ST_RD_CMD0) ? CMD_READ_SETUP :
                          (state_q == ST_RD_CMD30) ? CMD_READ_CONFIRM :
                          (state_q == ST_CACHE_CMD) ? cache_cmd : addr_byte;

    // request range check against block size
    wire [PAGE_BITS+1:0] req_end = {1'b0, req.count} + (PAGE_BITS+2)'(req.page);
    wire req_bad = (req.count == '0) || (req_end > (PAGE_BITS+2)'(PAGES_PER_BLOCK));
    wire take = ce && req_valid && req_ready;
    wire step = ce && ph_q;
    wire xfer_push = (state_q == ST_XFER) && !ph_q;
    wire stat_ready = io_in[STAT_READY_BIT] && !line_busy;
    wire wb_done = (wb_q == '0);

    // pin decode from registered state
    assign pins.ce_n = (state_q == ST_IDLE) ? CE_N_RST : 1'b0;
    assign pins.cle = (state_q != ST_RD_ADDR) && is_write_step(state_q);
    assign pins.ale = (state_q == ST_RD_ADDR);
    assign pins.we_n = !(is_write_step(state_q) && !ph_q);
    assign pins.re_n = !(is_read_step(state_q) && !ph_q);
    assign pins.wp_n = wp_n_q;
    assign pins.io_out = cmd_byte;
    assign pins.io_oe = is_write_step(state_q);

    assign req_ready = (state_q == ST_IDLE);
    assign req_err = err_q;
    assign run_done = done_q;
    assign init_done = init_done_q;

    // next state; read strobes stretch while the buffer is full
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_INIT_CMD: if (step) state_d = ST_INIT_POLL;
            ST_INIT_POLL: if (ce && !ph_q && stat_ready) state_d = ST_IDLE;
            ST_IDLE: if (take && !req_bad) state_d = ST_RD_CMD0;
            ST_RD_CMD0: if (step) state_d = ST_RD_ADDR;
            ST_RD_ADDR: if (step && cnt_q == BW'(ADDR_CYCLES - 1)) state_d = ST_RD_CMD30;
            ST_RD_CMD30: if (step) state_d = ST_WAIT_RDY;
            ST_WAIT_RDY: begin
                if (ce && wb_done && !line_busy) begin
                    state_d = in_cache_q ? ST_XFER : ST_CACHE_CMD;
                end
            end
            ST_CACHE_CMD: if (step) state_d = ST_WAIT_RDY;
            ST_XFER: begin
                if (step && cnt_q == BW'(PAGE_BYTES - 1)) begin
                    state_d = (left_q == '0) ? ST_IDLE : ST_CACHE_CMD;
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    // main sequencer registers
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= ST_INIT_CMD;
            ph_q <= 1'b0;
            cnt_q <= '0;
            left_q <= '0;
            run_q <= '0;
            wb_q <= '0;
            in_cache_q <= 1'b0;
            init_done_q <= 1'b0;
        end else if (ce) begin
            state_q <= state_d;
            // ST_XFER read low phase ends only when the byte is taken
            if (is_write_step(state_q) || (state_q == ST_INIT_POLL)) ph_q <= !ph_q;
            else if (state_q == ST_XFER) ph_q <= ph_q ? 1'b0 : buf_in_ready;
            else ph_q <= 1'b0;
            if (state_q != state_d) cnt_q <= '0;
            else if ((state_q == ST_RD_ADDR || state_q == ST_XFER) && ph_q) begin
                cnt_q <= cnt_q + BW'(1);
            end
            if (take && !req_bad) begin
                run_q <= req;
                left_q <= req.count;
                in_cache_q <= 1'b0;
            end
            if (state_q == ST_CACHE_CMD && ph_q) begin
                left_q <= left_q - (PAGE_BITS+1)'(1);
                in_cache_q <= 1'b1;
            end
            if (state_d == ST_WAIT_RDY && state_q != ST_WAIT_RDY) wb_q <= WB_CYCLES[$bits(wb_q)-1:0];
            else if (!wb_done) wb_q <= wb_q - 1'b1;
            if (state_q == ST_INIT_POLL && state_d == ST_IDLE) init_done_q <= 1'b1;
        end
    end

    // write-protect moves only when idle and the line is ready
    wire wp_may_move = (state_q == ST_IDLE) && !line_busy;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            wp_n_q <= WP_N_RST;
        end else if (ce && wp_may_move) begin
            wp_n_q <= pwr_ok && wp_release && init_done_q;
        end
    end

    // one-cycle answers to a request
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            err_q <= 1'b0;
            done_q <= 1'b0;
            confirm_seen_q <= 1'b0;
        end else if (ce) begin
            err_q <= take && req_bad;
            done_q <= (state_q == ST_XFER) && (state_d == ST_IDLE);
            if (state_q == ST_IDLE) confirm_seen_q <= 1'b0;
            else if (state_q == ST_RD_CMD30 && ph_q) confirm_seen_q <= 1'b1;
        end
    end

    // two-entry buffer absorbs a stalled receiver without losing a byte
    ncr_buf #(
        .WIDTH(8),
        .DEPTH(BUF_DEPTH)
    ) u_buf (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .ce(ce),
        .in_valid(xfer_push),
        .in_ready(buf_in_ready),
        .in_data(io_in),
        .out_valid(dout_valid),
        .out_ready(dout_ready),
        .out_data(dout_data)
    );

    // checks on the flash-side sequence
    property p_block_limit;
        @(posedge core_clk) disable iff (!arst_n)
        (take && req_bad) |=> (req_err && state_q == ST_IDLE);
    endproperty
    a_block_limit: assert property (p_block_limit) else $error("bad run accepted");

    property p_confirm_first;
        @(posedge core_clk) disable iff (!arst_n)
        (state_q == ST_CACHE_CMD && !pins.we_n) |-> confirm_seen_q;
    endproperty
    a_confirm_first: assert property (p_confirm_first) else $error("31h before 30h");

    property p_last_cmd;
        @(posedge core_clk) disable iff (!arst_n)
        (state_q == ST_CACHE_CMD && left_q == (PAGE_BITS+1)'(1)) |-> pins.io_out == 8'h3f;
    endproperty
    a_last_cmd: assert property (p_last_cmd) else $error("last page not 3fh");

    property p_line_busy;
        @(posedge core_clk) disable iff (!arst_n)
        (state_q == ST_WAIT_RDY && !rb_n) |=> state_q == ST_WAIT_RDY;
    endproperty
    a_line_busy: assert property (p_line_busy) else $error("left wait while busy");

    property p_init_status;
        @(posedge core_clk) disable iff (!arst_n)
        (!init_done && !pins.we_n) |-> (pins.io_out == 8'h70 && pins.cle);
    endproperty
    a_init_status: assert property (p_init_status) else $error("non-70h during init");

    property p_wp_busy;
        @(posedge core_clk) disable iff (!arst_n)
        (!rb_n && pins.wp_n) |=> pins.wp_n;
    endproperty
    a_wp_busy: assert property (p_wp_busy) else $error("wp asserted while busy");

    property p_wp_hold;
        @(posedge core_clk) disable iff (!arst_n)
        (state_q != ST_IDLE) |=> $stable(pins.wp_n);
    endproperty
    a_wp_hold: assert property (p_wp_hold) else $error("wp moved mid operation");

    property p_wp_power;
        @(posedge core_clk) disable iff (!arst_n)
        (!pwr_ok && ce && state_q == ST_IDLE && rb_n) |=> !pins.wp_n;
    endproperty
    a_wp_power: assert property (p_wp_power) else $error("wp high with power off");

    property p_ready_first;
        @(posedge core_clk) disable iff (!arst_n)
        (state_q == ST_XFER && $past(state_q) == ST_WAIT_RDY) |-> $past(rb_n, 1);
    endproperty
    a_ready_first: assert property (p_ready_first) else $error("readout before ready");

    c_init: cover property (@(posedge core_clk) disable iff (!arst_n) $rose(init_done));
    c_run: cover property (@(posedge core_clk) disable iff (!arst_n) run_done);
    c_stall: cover property (@(posedge core_clk) disable iff (!arst_n)
        state_q == ST_XFER && !buf_in_ready);
    c_last: cover property (@(posedge core_clk) disable iff (!arst_n)
        state_q == ST_CACHE_CMD && pins.io_out == CMD_CACHE_LAST && !pins.we_n);
    c_wp_up: cover property (@(posedge core_clk) disable iff (!arst_n) $rose(pins.wp_n));

    // run-level checks; a cache command only follows a ready line
    property p_cmd_ready;
        @(posedge core_clk) disable iff (!arst_n)
        (state_q == ST_CACHE_CMD && $past(state_q) == ST_WAIT_RDY) |-> $past(rb_n, 1);
    endproperty
    a_cmd_ready: assert property (p_cmd_ready) else $error("cmd before ready");

    property p_wp_init;
        @(posedge core_clk) disable iff (!arst_n)
        !init_done |-> !pins.wp_n;
    endproperty
    a_wp_init: assert property (p_wp_init) else $error("wp lifted before init");

    property p_next_cmd;
        @(posedge core_clk) disable iff (!arst_n)
        (state_q == ST_CACHE_CMD && left_q > (PAGE_BITS+1)'(1)) |->
            pins.io_out == CMD_CACHE_NEXT;
    endproperty
    a_next_cmd: assert property (p_next_cmd) else $error("inner page not 31h");

    property p_confirm_write;
        @(posedge core_clk) disable iff (!arst_n)
        (state_q == ST_RD_CMD30 && !pins.we_n) |->
            (pins.io_out == CMD_READ_CONFIRM && pins.cle);
    endproperty
    a_confirm_write: assert property (p_confirm_write) else $error("bad confirm byte");
endmodule

// *** verification/ncr_flash_model.sv ***
// ncr_flash_model: behavioural flash for page, cache and status reads
// assumes strobes are sampled on core_clk rising edges; write strobes last one cycle, read strobes may stretch
`timescale 1ns/1ps
module ncr_flash_model import ncr_pkg::*; #(
    parameter int INIT_CYC = 20,
    parameter int RD_CYC = 10,
    parameter int CACHE_CYC = 4
) (
    // clock and power-up reset
    input wire logic core_clk,
    input wire logic arst_n,
    // flash pins
    input wire ncr_pins_t pins,
    output logic [7:0] io_in,
    output logic rb_pull,
    // sticky protocol fault
    output logic viol
);
    logic [7:0] cnt_q;
    logic [7:0] last_q;
    logic [23:0] row_q;
    logic [5:0] dpg_q;
    logic [5:0] cpg_q;
    logic [3:0] idx_q;
    logic init_q, stat_q, loaded_q, re_q, wp_q, wr, rd;
    logic [7:0] val;
    logic [7:0] cmd;

    // strobe decode and read data
    assign wr = !pins.ce_n && !pins.we_n;
    assign rd = !pins.ce_n && !pins.re_n;
    assign cmd = pins.io_out;
    assign rb_pull = cnt_q != 8'h00;
    assign val = stat_q ? {pins.wp_n, !rb_pull, !rb_pull, 5'h00} : {cpg_q[3:0], idx_q};
    assign io_in = rd ? val : ~last_q; // released bus never holds its value

    // command sequencer; faults only flagged, never answered kindly
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= 8'(INIT_CYC);
            init_q <= 1'b1;
            {stat_q, loaded_q, viol, wp_q} <= 4'h0;
            {idx_q, last_q, row_q, dpg_q, cpg_q} <= '0;
            re_q <= 1'b1;
        end else begin
            re_q <= pins.re_n;
            wp_q <= pins.wp_n;
            if (rb_pull) cnt_q <= cnt_q - 8'h01;
            else init_q <= 1'b0;
            if (rd) last_q <= val;
            if (!re_q && pins.re_n) idx_q <= idx_q + 4'h1;
            if (rb_pull && wp_q && !pins.wp_n) viol <= 1'b1;
            // host must drive io on writes and release it on reads
            if ((wr && !pins.io_oe) || (rd && pins.io_oe)) viol <= 1'b1;
            if (rd && rb_pull && !stat_q) viol <= 1'b1;
            if (wr && pins.ale) row_q <= {cmd, row_q[23:8]};
            if (wr && pins.cle) begin
                stat_q <= cmd == CMD_STATUS;
                if ((init_q || rb_pull) && cmd != CMD_STATUS) viol <= 1'b1;
                if (cmd == CMD_READ_CONFIRM) begin
                    dpg_q <= row_q[5:0];
                    loaded_q <= 1'b1;
                    cnt_q <= 8'(RD_CYC);
                end
                if (cmd == CMD_CACHE_NEXT || cmd == CMD_CACHE_LAST) begin
                    cpg_q <= dpg_q;
                    idx_q <= 4'h0;
                    cnt_q <= 8'(CACHE_CYC);
                    if (!loaded_q) viol <= 1'b1;
                end
                if (cmd == CMD_CACHE_NEXT) begin
                    dpg_q <= dpg_q + 6'h01;
                    if (dpg_q == 6'h3f) viol <= 1'b1;
                end
                if (cmd == CMD_CACHE_LAST) loaded_q <= 1'b0;
            end
        end
    end
endmodule

// *** verification/nand_cache_read_busy_protect_bench.sv ***
// nand_cache_read_busy_protect_bench: host controller against the flash model
// assumes a second device on the wired busy line, played by other_pull
`timescale 1ns/1ps
module nand_cache_read_busy_protect_bench import ncr_pkg::*;;
    localparam int PB = 4;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic req_valid = 1'b0;
    ncr_req_t req = '0;
    logic dout_ready = 1'b0;
    logic pwr_ok = 1'b0;
    logic wp_release = 1'b0;
    logic other_pull = 1'b1;
    logic ce_on = 1'b1;
    logic wp_pin;
    logic req_ready, req_err, run_done, dout_valid, init_done, rb_pull, viol, rb_n;
    logic [7:0] dout_data;
    logic [7:0] io_in;
    ncr_pins_t pins;
    logic [7:0] got[$];
    logic [7:0] cyc = 8'h00;
    int stall_mode = 0;
    int err_total = 0;
    int comparisons = 0;

    // wired busy line: any device pulling low means busy
    assign rb_n = !(rb_pull || other_pull);
    // plain alias: a packed struct member cannot be passed by reference
    assign wp_pin = pins.wp_n;

    initial begin
        forever #20 core_clk = ~core_clk;
    end

    ncr_host #(.PAGE_BYTES(PB)) DUT (
        .core_clk(core_clk), .arst_n(arst_n), .ce(ce_on),
        .req_valid(req_valid), .req_ready(req_ready), .req(req), .req_err(req_err),
        .run_done(run_done), .dout_valid(dout_valid), .dout_ready(dout_ready),
        .dout_data(dout_data), .pwr_ok(pwr_ok), .wp_release(wp_release),
        .init_done(init_done), .pins(pins), .io_in(io_in), .rb_n(rb_n)
    );
    ncr_flash_model u_flash (
        .core_clk(core_clk), .arst_n(arst_n), .pins(pins), .io_in(io_in),
        .rb_pull(rb_pull), .viol(viol)
    );

    // receiver: 0 always ready, 1 stalls half the time, 2 stalls fully
    always @(posedge core_clk) begin
        cyc <= cyc + 8'h01;
        dout_ready <= stall_mode == 0 || (stall_mode == 1 && cyc[1]);
        if (dout_valid && dout_ready) got.push_back(dout_data);
    end

    task automatic check(input string nm, input logic [7:0] exp, input logic [7:0] seen);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // wait until a flag reaches a level, bounded
    task automatic wait_for(ref logic sig, input logic lvl);
        int n;
        n = 0;
        while (sig !== lvl && n < 300) begin
            @(negedge core_clk);
            n++;
        end
    endtask

    task automatic t_init;
        repeat (3) @(posedge core_clk);
        check("io_out", CMD_STATUS, pins.io_out);
        check("wp_n", 8'(WP_N_RST), 8'(pins.wp_n));
        arst_n <= 1'b1;
        repeat (60) @(negedge core_clk);
        check("init_done held", 8'h00, 8'(init_done));
        @(posedge core_clk);
        other_pull <= 1'b0;
        wait_for(init_done, 1'b1);
        check("init_done", 8'h01, 8'(init_done));
    endtask

    task automatic t_req(input logic [5:0] pg, input logic [6:0] cnt);
        wait_for(req_ready, 1'b1);
        @(posedge core_clk);
        req <= '{10'h2a5, pg, cnt};
        req_valid <= 1'b1;
        @(posedge core_clk);
        req_valid <= 1'b0;
        @(negedge core_clk);
    endtask

    task automatic t_refuse(input logic [5:0] pg, input logic [6:0] cnt);
        t_req(pg, cnt);
        check("req_err", 8'h01, 8'(req_err));
        check("req_ready", 8'h01, 8'(req_ready));
    endtask

    task automatic t_wp_on;
        check("wp_n power low", 8'h00, 8'(pins.wp_n));
        @(posedge core_clk);
        pwr_ok <= 1'b1;
        wp_release <= 1'b1;
        wait_for(wp_pin, 1'b1);
        check("wp_n released", 8'h01, 8'(pins.wp_n));
    endtask

    // clock enable low: a pending good request must not be taken
    task automatic t_freeze;
        @(posedge core_clk);
        ce_on <= 1'b0;
        req <= '{10'h2a5, 6'd0, 7'd1};
        req_valid <= 1'b1;
        repeat (3) @(posedge core_clk);
        req_valid <= 1'b0;
        ce_on <= 1'b1;
        @(negedge core_clk);
        check("req_ready frozen", 8'h01, 8'(req_ready));
        check("ce_n frozen", 8'h01, 8'(pins.ce_n));
        check("req_err frozen", 8'h00, 8'(req_err));
    endtask

    task automatic t_run(input logic [5:0] pg, input logic [6:0] cnt, input int sm, input bit drop);
        int n;
        int wp_bad;
        got.delete();
        stall_mode <= sm;
        t_req(pg, cnt);
        wp_bad = 0;
        n = 0;
        while (run_done !== 1'b1 && n < 3000) begin
            @(negedge core_clk);
            n++;
            if (pins.wp_n !== 1'b1) wp_bad++;
            // power drop driven on a rising edge, then back to the sampling rhythm
            if (n == 20 && drop) begin
                @(posedge core_clk);
                pwr_ok <= 1'b0;
                @(negedge core_clk);
                n++;
                if (pins.wp_n !== 1'b1) wp_bad++;
            end
            if (sm == 2 && n == 80) begin
                check("re_n held", 8'h00, 8'(pins.re_n));
                check("dout_valid", 8'h01, 8'(dout_valid));
                stall_mode <= 1;
            end
        end
        check("run_done", 8'h01, 8'(run_done));
        check("wp_n drops", 8'h00, 8'(wp_bad));
        n = 0;
        while (got.size() < cnt * PB && n < 200) begin
            @(negedge core_clk);
            n++;
        end
        check("bytes", 8'(cnt * PB), 8'(got.size()));
        for (int i = 0; i < cnt * PB; i++) begin
            check("data", {4'(pg + i / PB), 4'(i % PB)}, got[i]);
        end
        if (drop) begin
            wait_for(wp_pin, 1'b0);
            check("wp_n after", 8'h00, 8'(pins.wp_n));
        end
    endtask

    initial begin
        t_init();
        t_refuse(6'd62, 7'd3);
        t_refuse(6'd5, 7'd0);
        t_wp_on();
        t_freeze();
        t_run(6'd61, 7'd3, 2, 1'b0);
        t_run(6'd0, 7'd1, 1, 1'b1);
        check("model fault", 8'h00, 8'(viol));
        tally_and_finish();
    end

    // watchdog well beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge core_clk);
        err_total++;
        $display("Error watchdog expected done seen hang");
        tally_and_finish();
    end
endmodule
